// ===== hw/awt_top.sv
`default_nettype none
`include "awt_params.svh"

module awt_top (
  input  wire logic                i_clock,
  input  wire logic                i_srst,
  input  wire awt_pkg::awt_wb_req_t i_wb,
  input  wire logic                i_low_speed_rc_osc,
  output logic [31:0]              o_wb_dat,
  output logic                     o_wb_ack,
  output logic                     o_wake
);

  awt_pkg::awt_state_t st;       // Registered state of the block.
  awt_pkg::awt_state_t next_st;  // Next state.
  logic                lsi_tick; // One cycle per oscillator rising edge.
  logic                base_tick;// One cycle per prescaled period.
  logic                req;      // A new bus request this cycle.
  logic                wr;       // A write that lands this cycle.
  logic [7:0]          addr;     // Word-aligned byte address.

  // Divides the oscillator ticks by the selected ratio.
  awt_prescaler u_psc (
    .i_clock    (i_clock),
    .i_srst     (i_srst),
    .i_run      (st.enable),
    .i_lsi_tick (lsi_tick),
    .i_select   (st.select),
    .o_tick     (base_tick)
  );

  // Computes the next state: bus slave, synchroniser and counter.
  always_comb begin
    next_st = st;
    // The oscillator pin passes two flops before the edge detector.
    next_st.sync1 = i_low_speed_rc_osc;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    lsi_tick = st.sync2 && !st.sync3;
    addr = {i_wb.adr[7:2], 2'b00};
    // A request is answered once; the cycle after ack is idle.
    req = i_wb.cyc && i_wb.stb && !st.ack;
    // A write lands on the edge at which the master sees ack, while it still holds the request.
    wr = i_wb.cyc && i_wb.stb && i_wb.we && i_wb.sel[0] && st.ack;
    next_st.ack = req;
    next_st.rdat = st.rdat;
    if (req) begin
      // Read data; unmapped addresses and reserved bits read zero.
      case (addr)
        `AWT_OFS_CTRL: begin
          next_st.rdat = '0;
          next_st.rdat[`AWT_EN_BIT] = st.enable;
        end
        `AWT_OFS_WINDOW: begin
          next_st.rdat = {{(32 - `AWT_WIN_W){1'b0}}, st.window};
        end
        `AWT_OFS_PSC: begin
          next_st.rdat = {{(32 - `AWT_PSC_W){1'b0}}, st.select};
        end
        `AWT_OFS_COUNT: begin
          next_st.rdat = {{(32 - `AWT_WIN_W){1'b0}}, st.count};
        end
        default: begin
          next_st.rdat = '0;
        end
      endcase
    end
    // Writes land on the acknowledging edge; only lane 0 holds fields.
    if (wr) begin
      case (addr)
        `AWT_OFS_CTRL: begin
          next_st.enable = i_wb.dat[`AWT_EN_BIT];
        end
        `AWT_OFS_WINDOW: begin
          next_st.window = i_wb.dat[`AWT_WIN_W-1:0];
        end
        `AWT_OFS_PSC: begin
          next_st.select = i_wb.dat[`AWT_PSC_W-1:0];
        end
        default: begin
          // Read-only or unmapped: the write is dropped.
          next_st.select = st.select;
        end
      endcase
    end
    next_st.wake = 1'b0;
    if (!st.enable) begin
      next_st.count = '0;
    end else if (base_tick) begin
      if (st.count == st.window) begin
        next_st.count = '0;
        next_st.wake = 1'b1;
      end else begin
        next_st.count = st.count + `AWT_WIN_W'(1);
      end
    end
  end

  // Registers the whole state; reset loads the power-up register values.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st <= '0;
      st.enable <= `AWT_EN_RESET;
      st.window <= `AWT_WIN_RESET;
      st.select <= `AWT_PSC_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops.
  assign o_wb_dat = st.rdat;
  assign o_wb_ack = st.ack;
  assign o_wake = st.wake;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  // A base tick that finds the counter at the window value.
  sequence s_match;
    st.enable && base_tick && st.count == st.window;
  endsequence

  // The following cycle restarts the counter with a wake pulse.
  sequence s_restart;
    o_wake && st.count == '0;
  endsequence

  enable_off_idle_a: assert property (
    !st.enable |=> (st.count == '0 && !o_wake))
    else $error("disabled timer counted or woke");

  enable_write_a: assert property (
    (wr && addr == `AWT_OFS_CTRL) |=> st.enable == $past(i_wb.dat[`AWT_EN_BIT]))
    else $error("enable bit did not follow the write");

  window_plus_one_a: assert property (
    o_wake |-> $past(st.count) == $past(st.window))
    else $error("wake not at effective window");

  count_step_a: assert property (
    (st.enable && base_tick && st.count != st.window)
      |=> st.count == $past(st.count) + `AWT_WIN_W'(1))
    else $error("counter did not step by one");

  count_hold_a: assert property (
    (st.enable && !base_tick) |=> $stable(st.count))
    else $error("counter moved without a time base tick");

  match_wake_a: assert property (
    s_match |=> s_restart)
    else $error("match did not raise wake and restart");

  osc_edge_a: assert property (
    lsi_tick |-> ($past(i_low_speed_rc_osc, 2) && !$past(st.sync2)))
    else $error("oscillator tick without a synchronised edge");

  // Bus ack lasts one cycle.
  bus_ack_once_a: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held for more than one cycle");

endmodule // awt_top

`default_nettype wire

// ===== hw/awt_params.svh
`ifndef AWT_PARAMS_SVH
`define AWT_PARAMS_SVH

// Register byte offsets on the bus.
`define AWT_OFS_CTRL    8'h08
`define AWT_OFS_WINDOW  8'h0c
`define AWT_OFS_PSC     8'h10
`define AWT_OFS_COUNT   8'h14

// Field positions and widths.
`define AWT_EN_BIT      1
`define AWT_WIN_W       6
`define AWT_PSC_W       4
`define AWT_DIV_W       16

// Reset values.
`define AWT_EN_RESET    1'b0
`define AWT_WIN_RESET   6'h3f
`define AWT_PSC_RESET   4'h0

// Divider select codes.
`define AWT_SEL_OFF     4'h0
`define AWT_SEL_RSV0    4'h1
`define AWT_SEL_D2      4'h2
`define AWT_SEL_D4      4'h3
`define AWT_SEL_D8      4'h4
`define AWT_SEL_D16     4'h5
`define AWT_SEL_D32     4'h6
`define AWT_SEL_D256    4'h7
`define AWT_SEL_D128    4'h8
`define AWT_SEL_D512    4'h9
`define AWT_SEL_RSV1    4'ha
`define AWT_SEL_D1024   4'hb
`define AWT_SEL_D2048   4'hc
`define AWT_SEL_D4096   4'hd
`define AWT_SEL_D10240  4'he
`define AWT_SEL_D61440  4'hf

// Division ratios; zero marks a halted time base.
`define AWT_DIV_HALT    16'h0000
`define AWT_DIV_1       16'h0001
`define AWT_DIV_2       16'h0002
`define AWT_DIV_4       16'h0004
`define AWT_DIV_8       16'h0008
`define AWT_DIV_16      16'h0010
`define AWT_DIV_32      16'h0020
`define AWT_DIV_128     16'h0080
`define AWT_DIV_256     16'h0100
`define AWT_DIV_512     16'h0200
`define AWT_DIV_1024    16'h0400
`define AWT_DIV_2048    16'h0800
`define AWT_DIV_4096    16'h1000
`define AWT_DIV_10240   16'h2800
`define AWT_DIV_61440   16'hf000

`endif

// ===== hw/awt_pkg.sv
`default_nettype none
`include "awt_params.svh"

package awt_pkg;

  // Wishbone request from the master, sampled as one group.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } awt_wb_req_t;

  // Prescaler state.
  typedef struct packed {
    logic [`AWT_DIV_W-1:0] cnt;
    logic                  tick;
  } awt_psc_state_t;

  // Top-level state: registers, synchroniser, counter and bus answer.
  typedef struct packed {
    logic                  enable;
    logic [`AWT_WIN_W-1:0] window;
    logic [`AWT_PSC_W-1:0] select;
    logic [`AWT_WIN_W-1:0] count;
    logic                  wake;
    logic                  sync1;
    logic                  sync2;
    logic                  sync3;
    logic                  ack;
    logic [31:0]           rdat;
  } awt_state_t;

endpackage

`default_nettype wire

// ===== hw/awt_prescaler.sv
`default_nettype none
`include "awt_params.svh"

// Divides oscillator ticks down to the counting time base.
module awt_prescaler (
  input  wire logic                  i_clock,
  input  wire logic                  i_srst,
  input  wire logic                  i_run,
  input  wire logic                  i_lsi_tick,
  input  wire logic [`AWT_PSC_W-1:0] i_select,
  output logic                       o_tick
);

  // Maps a select code to its ratio; reserved codes halt the base.
  // Select code decode.
  function automatic logic [`AWT_DIV_W-1:0] awt_limit(input logic [`AWT_PSC_W-1:0] sel);
    case (sel)
      `AWT_SEL_OFF:    awt_limit = `AWT_DIV_1;
      `AWT_SEL_D2:     awt_limit = `AWT_DIV_2;
      `AWT_SEL_D4:     awt_limit = `AWT_DIV_4;
      `AWT_SEL_D8:     awt_limit = `AWT_DIV_8;
      `AWT_SEL_D16:    awt_limit = `AWT_DIV_16;
      `AWT_SEL_D32:    awt_limit = `AWT_DIV_32;
      `AWT_SEL_D256:   awt_limit = `AWT_DIV_256;
      `AWT_SEL_D128:   awt_limit = `AWT_DIV_128;
      `AWT_SEL_D512:   awt_limit = `AWT_DIV_512;
      `AWT_SEL_D1024:  awt_limit = `AWT_DIV_1024;
      `AWT_SEL_D2048:  awt_limit = `AWT_DIV_2048;
      `AWT_SEL_D4096:  awt_limit = `AWT_DIV_4096;
      `AWT_SEL_D10240: awt_limit = `AWT_DIV_10240;
      `AWT_SEL_D61440: awt_limit = `AWT_DIV_61440;
      default:         awt_limit = `AWT_DIV_HALT;
    endcase
  endfunction

  awt_pkg::awt_psc_state_t st;       // Registered state.
  awt_pkg::awt_psc_state_t next_st;  // Next state.
  logic [`AWT_DIV_W-1:0]   limit;    // Ratio of the current code.

  // Counts oscillator ticks and emits one pulse per full ratio.
  always_comb begin
    limit = awt_limit(i_select);
    next_st = st;
    next_st.tick = 1'b0;
    // Reserved codes and a disabled timer keep the divider cleared.
    // Reserved codes halt.
    if (!i_run || limit == `AWT_DIV_HALT) begin
      next_st.cnt = '0;
    end else if (i_lsi_tick) begin
      // The last tick of a ratio wraps the divider and fires the base.
      if (st.cnt == limit - `AWT_DIV_1) begin
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + `AWT_DIV_1;
      end
    end
  end

  // Registers the state; reset clears the divider.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  div_low_codes_a: assert property (
    (i_select == `AWT_SEL_OFF |-> limit == `AWT_DIV_1) and
    (i_select == `AWT_SEL_D2 |-> limit == `AWT_DIV_2) and
    (i_select == `AWT_SEL_D16 |-> limit == `AWT_DIV_16))
    else $error("low divider code decoded wrongly");

  div_mid_codes_a: assert property (
    (i_select == `AWT_SEL_D256 |-> limit == `AWT_DIV_256) and
    (i_select == `AWT_SEL_D128 |-> limit == `AWT_DIV_128) and
    (i_select == `AWT_SEL_D512 |-> limit == `AWT_DIV_512))
    else $error("middle divider code decoded wrongly");

  div_high_codes_a: assert property (
    (i_select == `AWT_SEL_D1024 |-> limit == `AWT_DIV_1024) and
    (i_select == `AWT_SEL_D10240 |-> limit == `AWT_DIV_10240) and
    (i_select == `AWT_SEL_D61440 |-> limit == `AWT_DIV_61440))
    else $error("high divider code decoded wrongly");

  reserved_code_halt_a: assert property (
    (i_select == `AWT_SEL_RSV0 || i_select == `AWT_SEL_RSV1) |=> !st.tick)
    else $error("reserved divider code produced a tick");

endmodule // awt_prescaler

`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none
`include "awt_params.svh"

// Compares a value with its expectation and counts the outcome.
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clock = 1'b0;        // Bench clock, 25 ns period.
  logic                 srst = 1'b1;         // Synchronous reset, active high.
  logic                 osc = 1'b0;          // Oscillator level fed to the block.
  logic [1:0]           osc_phase = 2'h0;    // Oscillator phase, two clocks high and two low.
  logic [31:0]          osc_edges = '0;      // Rising oscillator edges made so far.
  logic [31:0]          last_edge = '0;      // Edge count at the previous wake pulse.
  logic [31:0]          wakes = '0;          // Wake pulses seen so far.
  logic                 armed = 1'b0;        // A previous wake pulse marks the interval start.
  awt_pkg::awt_wb_req_t wb = '0;             // Bus request driven by the bench.
  logic [31:0]          rdat;                // Read data from the block.
  logic                 ack;                 // Bus acknowledge from the block.
  logic                 wake;                // Wake pulse from the block.
  logic [31:0]          rd_q[$];             // Expected read data, oldest first.
  logic [31:0]          gap_q[$];            // Expected edges between wake pulses.
  logic [31:0]          exp_v;               // Expectation taken off a queue.
  int                   mismatches = 0;      // Failed comparisons.
  int                   total_checks = 0;    // All comparisons.
  int                   cycles = 0;          // Clock cycles since start.

  awt_top awt_top_inst (
    .i_clock            (clock),
    .i_srst             (srst),
    .i_wb               (wb),
    .i_low_speed_rc_osc (osc),
    .o_wb_dat           (rdat),
    .o_wb_ack           (ack),
    .o_wake             (wake)
  );

  // The clock toggles every half period.
  always #12.5 clock = ~clock;

  // The oscillator is slower than the clock so the synchroniser sees every edge.
  always @(posedge clock) begin
    osc_phase <= osc_phase + 2'h1;
    osc <= osc_phase[1];
    if (osc_phase == 2'h2) begin
      osc_edges <= osc_edges + 32'h0000_0001;
    end
  end

  // Watches answers and wake pulses and compares them with the oldest note.
  always @(posedge clock) begin
    if (ack === 1'b1 && wb.we === 1'b0 && rd_q.size() > 0) begin
      exp_v = rd_q.pop_front();
      `CHK(rdat, exp_v)
    end
    if (wake === 1'b1) begin
      wakes++;
      if (armed && gap_q.size() > 0) begin
        exp_v = gap_q.pop_front();
        `CHK(osc_edges - last_edge, exp_v)
      end
      armed = 1'b1;
      last_edge = osc_edges;
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hang is cut short well above the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      summarize();
    end
  end

  // One classic bus cycle, held until the acknowledge is sampled.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do @(posedge clock); while (ack !== 1'b1);
    wb <= '0;
    @(posedge clock);
  endtask

  // A read notes its expected data before the request goes out.
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, adr, 32'h0000_0000, 4'hf);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    bus(1'b1, adr, dat, sel);
  endtask

  localparam logic [3:0]  codes [11] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb, 4'hc};
  localparam logic [31:0] ratios [11] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0008,
    32'h0000_0010, 32'h0000_0020, 32'h0000_0100, 32'h0000_0080, 32'h0000_0200, 32'h0000_0400, 32'h0000_0800};

  // Main sequence: reset, register access, eleven divider codes (0, 2 to 9, b, c), halted cases.
  initial begin
    logic [31:0] win;
    logic [31:0] base_wakes;
    win = $urandom(32'hc27a);
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(`AWT_OFS_CTRL, 32'h0000_0000);
    rd(`AWT_OFS_WINDOW, 32'h0000_003f);
    rd(`AWT_OFS_PSC, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    wr(`AWT_OFS_CTRL, 32'hffff_ffff, 4'hf);
    rd(`AWT_OFS_CTRL, 32'h0000_0002);
    wr(`AWT_OFS_WINDOW, 32'hffff_ffc5, 4'h0);
    rd(`AWT_OFS_WINDOW, 32'h0000_003f);
    wr(`AWT_OFS_WINDOW, 32'hffff_ffc5, 4'hf);
    rd(`AWT_OFS_WINDOW, 32'h0000_0005);
    $display("register test done");
    for (int i = 0; i < 11; i++) begin
      wr(`AWT_OFS_CTRL, 32'h0000_0000, 4'hf);
      win = (ratios[i] <= 32'h0000_0020) ? {28'h0, 4'($urandom)} : 32'h0000_0000;
      wr(`AWT_OFS_WINDOW, win, 4'hf);
      wr(`AWT_OFS_PSC, {28'h0, codes[i]}, 4'hf);
      rd(`AWT_OFS_PSC, {28'h0, codes[i]});
      armed = 1'b0;
      gap_q.push_back((win + 32'h0000_0001) * ratios[i]);
      wr(`AWT_OFS_CTRL, 32'h0000_0002, 4'hf);
      while (gap_q.size() != 0) @(posedge clock);
      $display("divider code %h test done", codes[i]);
    end
    wr(`AWT_OFS_CTRL, 32'h0000_0000, 4'hf);
    // The slowest codes are only written and read back; assertions check the decode of codes e and f, not of code d.
    for (int c = 13; c < 16; c++) begin
      wr(`AWT_OFS_PSC, c, 4'hf);
      rd(`AWT_OFS_PSC, c);
    end
    wr(`AWT_OFS_WINDOW, 32'h0000_0000, 4'hf);
    base_wakes = wakes;
    wr(`AWT_OFS_PSC, 32'h0000_0001, 4'hf);
    wr(`AWT_OFS_CTRL, 32'h0000_0002, 4'hf);
    repeat (400) @(posedge clock);
    wr(`AWT_OFS_PSC, 32'h0000_000a, 4'hf);
    repeat (400) @(posedge clock);
    rd(`AWT_OFS_COUNT, 32'h0000_0000);
    // Disable first, so the fast code below can never fire.
    wr(`AWT_OFS_CTRL, 32'h0000_0000, 4'hf);
    wr(`AWT_OFS_PSC, 32'h0000_0000, 4'hf);
    repeat (400) @(posedge clock);
    `CHK(wakes, base_wakes)
    $display("halted and disabled test done");
    summarize();
  end
endmodule // tb_top

`default_nettype wire
